/* File: hw/lockdown_pkg.sv */
/*
  Constants, command codes and carrier types for the sector protection
  and lockdown command logic. Assumes a 100 MHz system clock.
*/
package lockdown_pkg;

  localparam int          CLK_PERIOD_NS       = 10;
  localparam int          PROG_CYCLE_TIME_US  = 4000;
  localparam int          FREEZE_TIME_US      = 200;
  localparam int          PROG_CYCLES         = PROG_CYCLE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int          FREEZE_CYCLES       = FREEZE_TIME_US * 1000 / CLK_PERIOD_NS;

  localparam logic [7:0]  OP_READ_PROT        = 8'h32;
  localparam logic [7:0]  OP_READ_LOCK        = 8'h35;
  localparam logic [31:0] SEQ_LOCKDOWN        = 32'h3d2a7f30;
  localparam logic [31:0] SEQ_FREEZE          = 32'h3455aa40;

  localparam logic [2:0]  DUMMY_BYTES         = 3'h3;
  localparam logic [2:0]  ADDR_BYTES          = 3'h3;
  localparam logic [2:0]  CMD_BYTES           = 3'h4;
  localparam logic [7:0]  BYTE_ON             = 8'hff;
  localparam logic [7:0]  BYTE_OFF            = 8'h00;
  localparam logic [7:0]  HALF_0A             = 8'hc0;
  localparam logic [7:0]  HALF_0B             = 8'h30;
  localparam int          SECTOR_MSB          = 18;
  localparam int          HALF_BIT            = 11;
  localparam int          SUB0_MSB            = 16;

  localparam logic [63:0] LOCK_RESET          = 64'h0;
  localparam logic [63:0] PROT_RESET          = 64'h0;
  localparam logic [31:0] TIMER_WIDTH_ZERO    = 32'h0;

  typedef enum logic [2:0]
  {
    ST_OPCODE = 3'b000,
    ST_DUMMY  = 3'b001,
    ST_READ   = 3'b010,
    ST_CMD    = 3'b011,
    ST_ADDR   = 3'b100,
    ST_IGNORE = 3'b101
  } frame_state_t;

  typedef enum logic [1:0]
  {
    CMD_NONE   = 2'b00,
    CMD_RPROT  = 2'b01,
    CMD_RLOCK  = 2'b10
  } read_sel_t;

  typedef struct packed
  {
    logic       busy;
    logic       lock_cmd_enable_flag;
  } status_t;

endpackage : lockdown_pkg

/* File: hw/sector_protect_lockdown_cmds.sv */
/*
  Command logic for sector protection read, sector lockdown, lockdown read
  and lockdown freeze. Assumes SPI mode 0 pins sampled synchronously to
  I_CLK, with serial clock well below a quarter of the system clock.
*/
`timescale 1ns/100ps

// What this block does
// - Protection bytes 0 to 7 shift out for sectors 0 to 7.
// - Clocks after the eighth protection byte give undefined data.
// - Chip-select release ends a register read and floats the output.
// - Release after the address starts a timed lockdown, busy throughout.
// - Locked sectors reject erase and program; only I_RST unlocks them.
// - Lockdown bytes 0 to 7 shift out for sectors 0 to 7.
// - Lockdown byte reads FFh locked, 00h unlocked for sectors 1 to 7.
// - Byte 0 uses bits 7:6 and 5:4 for halves 0a and 0b.
// - Clocks after the eighth lockdown byte give undefined data.
// - Bytes after the four freeze bytes are ignored.
// - Release after freeze fixes lockdown state and clears the enable flag.
// - After freeze the sector lockdown command is ignored.
// - Protection bytes use FFh/00h, byte 0 split into two halves.
module sector_protect_lockdown_cmds
  import lockdown_pkg::*;
#(
  parameter int PROG_COUNT   = PROG_CYCLES,
  parameter int FREEZE_COUNT = FREEZE_CYCLES
)
(
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_CS_N,
  input  wire logic        I_SCK,
  input  wire logic        I_SI,
  input  wire logic [63:0] I_PROT,
  input  wire logic [18:0] I_WR_ADDR,
  output logic             O_SO,
  output logic             O_SO_OE_N,
  output logic             O_BUSY,
  output logic             O_LOCK_CMD_ENABLE,
  output logic             O_WR_DENY,
  output logic [63:0]      O_LOCK_STATE
);

  function automatic logic [7:0] sector_byte(input logic [63:0] reg64, input logic [2:0] idx);
    sector_byte = reg64[8'(63 - 8 * idx) -: 8];
  endfunction : sector_byte

  function automatic logic [63:0] lock_mask(input logic [18:0] addr);
    logic [63:0] m;
    logic [2:0]  s;
    m = 64'h0;
    s = addr[SECTOR_MSB -: 3];
    if (s != 3'h0)
      m[8'(63 - 8 * s) -: 8] = BYTE_ON;
    else if (addr[SUB0_MSB:HALF_BIT] == 6'h0)
      m[63 -: 8] = HALF_0A;
    else if (addr[SUB0_MSB:HALF_BIT + 1] == 5'h0)
      m[63 -: 8] = HALF_0B;
    lock_mask = m;
  endfunction : lock_mask

  function automatic logic denied(input logic [63:0] st, input logic [18:0] addr);
    denied = (lock_mask(addr) & st) != 64'h0;
  endfunction : denied

  // Pin edge detection; inputs are already synchronous.
  logic         sck_q;
  logic         cs_q;
  logic         sck_rise;
  logic         sck_fall;
  logic         cs_rise;
  logic         cs_low;

  frame_state_t state;
  frame_state_t next_state;
  read_sel_t    sel;
  read_sel_t    next_sel;
  logic [31:0]  shreg;
  logic [31:0]  next_shreg;
  logic [2:0]   bitcnt;
  logic [2:0]   next_bitcnt;
  logic [2:0]   bytecnt;
  logic [2:0]   next_bytecnt;
  logic [3:0]   outbyte;
  logic [3:0]   next_outbyte;
  logic [1:0]   pend;
  logic [1:0]   next_pend;
  logic [63:0]  lock_state;
  logic [63:0]  next_lock_state;
  logic         frozen;
  logic         next_frozen;
  logic [31:0]  timer;
  logic [31:0]  next_timer;
  logic [18:0]  lock_addr;
  logic [18:0]  next_lock_addr;
  logic         job;
  logic         next_job;
  logic         so;
  logic         next_so;
  logic         so_oe_n;
  logic         next_so_oe_n;
  logic [7:0]   cur_byte;
  logic [7:0]   byte_in;

  assign sck_rise = I_SCK & ~sck_q;
  assign sck_fall = ~I_SCK & sck_q;
  assign cs_rise  = I_CS_N & ~cs_q;
  assign cs_low   = ~I_CS_N;
  assign byte_in  = {shreg[6:0], I_SI};

  always_comb
  begin
    cur_byte = BYTE_OFF;
    if (sel == CMD_RPROT)
      cur_byte = sector_byte(I_PROT, outbyte[2:0]);
    else if (sel == CMD_RLOCK)
      cur_byte = sector_byte(lock_state, outbyte[2:0]);
  end

  always_comb
  begin
    next_state      = state;
    next_sel        = sel;
    next_shreg      = shreg;
    next_bitcnt     = bitcnt;
    next_bytecnt    = bytecnt;
    next_outbyte    = outbyte;
    next_pend       = pend;
    next_lock_state = lock_state;
    next_frozen     = frozen;
    next_timer      = timer;
    next_lock_addr  = lock_addr;
    next_job        = job;
    next_so         = so;
    next_so_oe_n    = so_oe_n;
    if (timer != TIMER_WIDTH_ZERO)
    begin
      next_timer = timer - 32'h1;
      if (timer == 32'h1)
      begin
        if (job)
          next_frozen = 1'b1;
        else
          next_lock_state = lock_state | lock_mask(lock_addr);
      end
    end
    if (cs_rise)
    begin
      next_so_oe_n = 1'b1;
      next_sel     = CMD_NONE;
      next_state   = ST_OPCODE;
      next_bitcnt  = 3'h0;
      next_bytecnt = 3'h0;
      next_outbyte = 4'h0;
      if (timer == TIMER_WIDTH_ZERO)
      begin
        if (pend == 2'b01 && !frozen)
        begin
          next_timer = 32'(PROG_COUNT);
          next_job   = 1'b0;
        end
        else if (pend == 2'b10)
        begin
          next_timer = 32'(FREEZE_COUNT);
          next_job   = 1'b1;
        end
      end
      next_pend = 2'b00;
    end
    else if (cs_low && sck_rise && state != ST_READ)
    begin
      next_shreg  = {shreg[30:0], I_SI};
      next_bitcnt = bitcnt + 3'h1;
      if (bitcnt == 3'h7)
      begin
        next_bytecnt = bytecnt + 3'h1;
        case (state)
          ST_OPCODE:
          begin
            if (byte_in == OP_READ_PROT)
            begin
              next_sel = CMD_RPROT; next_state = ST_DUMMY; next_bytecnt = 3'h0;
            end
            else if (byte_in == OP_READ_LOCK)
            begin
              next_sel = CMD_RLOCK; next_state = ST_DUMMY; next_bytecnt = 3'h0;
            end
            else
              next_state = ST_CMD;
          end
          ST_DUMMY:
            if (bytecnt == DUMMY_BYTES - 3'h1)
            begin
              next_state   = ST_READ;
              next_so_oe_n = 1'b0;
              next_so      = cur_byte[7];
              next_bitcnt  = 3'h0;
            end
          ST_CMD:
            if (bytecnt == CMD_BYTES - 3'h1)
            begin
              next_bytecnt = 3'h0;
              if ({shreg[30:0], I_SI} == SEQ_LOCKDOWN)
                next_state = ST_ADDR;
              else
              begin
                if ({shreg[30:0], I_SI} == SEQ_FREEZE)
                  next_pend = 2'b10;
                next_state = ST_IGNORE;
              end
            end
          ST_ADDR:
            if (bytecnt == ADDR_BYTES - 3'h1)
            begin
              next_lock_addr = {shreg[17:0], I_SI};
              next_pend      = 2'b01;
              next_state     = ST_IGNORE;
            end
          ST_IGNORE:
            next_pend = (pend == 2'b10) ? pend : 2'b00;
          default:
            next_state = ST_OPCODE;
        endcase
      end
    end
    else if (cs_low && sck_fall && state == ST_READ)
    begin
      // Past byte 7 the index wraps to data the host must treat as undefined.
      next_so     = cur_byte[3'h7 - bitcnt];
      next_bitcnt = bitcnt + 3'h1;
      if (bitcnt == 3'h7)
        next_outbyte = outbyte + 4'h1;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      sck_q      <= 1'b0;
      cs_q       <= 1'b1;
      state      <= ST_OPCODE;
      sel        <= CMD_NONE;
      shreg      <= 32'h0;
      bitcnt     <= 3'h0;
      bytecnt    <= 3'h0;
      outbyte    <= 4'h0;
      pend       <= 2'b00;
      lock_state <= LOCK_RESET;
      frozen     <= 1'b0;
      timer      <= 32'h0;
      lock_addr  <= 19'h0;
      job        <= 1'b0;
      so         <= 1'b0;
      so_oe_n    <= 1'b1;
    end
    else
    begin
      sck_q      <= I_SCK;
      cs_q       <= I_CS_N;
      state      <= next_state;
      sel        <= next_sel;
      shreg      <= next_shreg;
      bitcnt     <= next_bitcnt;
      bytecnt    <= next_bytecnt;
      outbyte    <= next_outbyte;
      pend       <= next_pend;
      lock_state <= next_lock_state;
      frozen     <= next_frozen;
      timer      <= next_timer;
      lock_addr  <= next_lock_addr;
      job        <= next_job;
      so         <= next_so;
      so_oe_n    <= next_so_oe_n;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_SO              <= 1'b0;
      O_SO_OE_N         <= 1'b1;
      O_BUSY            <= 1'b0;
      O_LOCK_CMD_ENABLE <= 1'b1;
      O_WR_DENY         <= 1'b0;
      O_LOCK_STATE      <= LOCK_RESET;
    end
    else
    begin
      O_SO              <= so;
      O_SO_OE_N         <= so_oe_n;
      O_BUSY            <= next_timer != TIMER_WIDTH_ZERO;
      O_LOCK_CMD_ENABLE <= ~next_frozen;
      O_WR_DENY         <= denied(lock_state, I_WR_ADDR);
      O_LOCK_STATE      <= lock_state;
    end
  end

  a_release_floats: assert property (@(posedge I_CLK) disable iff (I_RST)
    cs_rise |=> ##1 O_SO_OE_N)
    else $error("output not floated after chip-select release");

  a_lock_sticky: assert property (@(posedge I_CLK) disable iff (I_RST)
    (lock_state & ~$past(lock_state)) == 64'h0 || !frozen)
    else $error("lockdown state changed after freeze");

  a_bits_never_clear: assert property (@(posedge I_CLK) disable iff (I_RST)
    ($past(lock_state) & ~lock_state) == 64'h0)
    else $error("locked sector became unlocked");

  a_busy_follows: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cs_rise && pend == 2'b01 && !frozen && timer == 32'h0) |-> ##2 O_BUSY)
    else $error("lockdown did not raise busy");

  a_frozen_ignores: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cs_rise && frozen && pend == 2'b01) |=> timer == $past(timer) - 32'h1 || timer == 32'h0)
    else $error("lockdown accepted after freeze");

  a_enable_drops: assert property (@(posedge I_CLK) disable iff (I_RST)
    (frozen && !$past(frozen)) |=> !O_LOCK_CMD_ENABLE)
    else $error("enable flag not cleared by freeze");

  a_enable_stays: assert property (@(posedge I_CLK) disable iff (I_RST)
    $past(frozen) |-> frozen)
    else $error("freeze undone");

  a_short_frame: assert property (@(posedge I_CLK) disable iff (I_RST)
    (cs_rise && pend == 2'b00 && timer == 32'h0) |=> timer == 32'h0)
    else $error("incomplete frame started a cycle");

  a_byte0_format: assert property (@(posedge I_CLK) disable iff (I_RST)
    lock_state[59:56] == 4'h0)
    else $error("low bits of byte 0 set");

endmodule : sector_protect_lockdown_cmds

/* File: testbench/spi_host_model.sv */
/*
  Behavioural SPI mode 0 host that issues flash command frames.
  Assumes i_clk is the bench clock; pins change on its falling edge.
*/
`timescale 1ns/100ps
module spi_host_model
(
  input  wire logic i_clk,
  input  wire logic i_so,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si
);
  // Four clocks a phase keeps each phase above the three-cycle minimum.
  localparam int HALF = 4;

  initial
  begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b1;
  end

  task automatic gap();
    repeat (HALF) @(negedge i_clk);
  endtask : gap

  task automatic start();
    gap();
    o_cs_n = 1'b0;
  endtask : start

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      o_si = tx[i];
      gap();
      rx[i] = i_so;
      o_sck = 1'b1;
      gap();
      o_sck = 1'b0;
    end
    // A stale data bit would hide a sampling slip, so the line flips.
    o_si = ~o_si;
  endtask : xfer

  task automatic stop();
    gap();
    o_cs_n = 1'b1;
    gap();
  endtask : stop
endmodule : spi_host_model

/* File: testbench/tb.sv */
/*
  Self-checking bench for the lockdown command logic.
  Assumes the host model in spi_host_model.sv and short timer parameters.
*/
`timescale 1ns/100ps
module tb
  import lockdown_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic [63:0] prot = 64'hc0ff00ff0000ff00;
  logic [18:0] wr_addr = 19'h0;
  logic        so;
  logic        so_oe_n;
  logic        busy;
  logic        lock_en;
  logic        wr_deny;
  logic [63:0] lock_state;
  logic [63:0] exp = 64'h0;
  logic [63:0] rd;
  int          err_total = 0;
  int          num_checks = 0;
  logic [18:0] addrs[5] = '{19'h30000, 19'h20000, 19'h00000, 19'h00900, 19'h01000};
  logic        denies[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  always #5 clk = ~clk;

  sector_protect_lockdown_cmds #(.PROG_COUNT(10), .FREEZE_COUNT(10)) i_sector_protect_lockdown_cmds
  (
    .I_CLK             (clk),
    .I_RST             (rst),
    .I_CS_N            (cs_n),
    .I_SCK             (sck),
    .I_SI              (si),
    .I_PROT            (prot),
    .I_WR_ADDR         (wr_addr),
    .O_SO              (so),
    .O_SO_OE_N         (so_oe_n),
    .O_BUSY            (busy),
    .O_LOCK_CMD_ENABLE (lock_en),
    .O_WR_DENY         (wr_deny),
    .O_LOCK_STATE      (lock_state)
  );

  spi_host_model i_spi_host_model
  (
    .i_clk  (clk),
    .i_so   (so),
    .o_cs_n (cs_n),
    .o_sck  (sck),
    .o_si   (si)
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    num_checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic frame(input logic [63:0] hdr, input int n, input int nrd);
    logic [7:0] r;
    i_spi_host_model.start();
    for (int i = 0; i < n; i++)
      i_spi_host_model.xfer(hdr[63-8*i -: 8], r);
    rd = 64'h0;
    for (int i = 0; i < nrd; i++)
    begin
      i_spi_host_model.xfer(8'h00, r);
      rd[63-8*i -: 8] = r;
    end
    if (nrd > 0)
      check(so_oe_n, 1'b0);
    i_spi_host_model.stop();
  endtask : frame

  task automatic lock(input logic [23:0] a, input int n);
    frame({32'h3d2a7f30, a, 8'h00}, n, 0);
  endtask : lock

  task automatic wait_idle();
    for (int k = 0; k < 100 && busy !== 1'b0; k++)
      @(negedge clk);
    check(busy, 1'b0);
    // Lockdown state reaches its output one cycle after busy drops.
    @(negedge clk);
  endtask : wait_idle

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  initial
  begin
    #400000;
    err_total++;
    wrap_up();
  end

  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check(busy, 1'b0);
    check(lock_en, 1'b1);
    check(lock_state, 64'h0);
    // The protection register is never reprogrammed here.
    frame({8'h32, 56'h0}, 4, 8);
    check(rd, prot);
    check(so_oe_n, 1'b1);
    lock(24'h03abcd, 7);
    check(busy, 1'b1);
    wait_idle();
    exp[39:32] = 8'hff;
    check(lock_state, exp);
    lock(24'h000800, 7);
    wait_idle();
    exp[63:56] = 8'h30;
    check(lock_state, exp);
    lock(24'h000000, 7);
    wait_idle();
    exp[63:56] = 8'hf0;
    check(lock_state, exp);
    lock(24'h050000, 6);
    check(busy, 1'b0);
    check(lock_state, exp);
    frame({8'h35, 56'h0}, 4, 8);
    check(rd, exp);
    for (int i = 0; i < 5; i++)
    begin
      wr_addr = addrs[i];
      repeat (3) @(negedge clk);
      check(wr_deny, denies[i]);
    end
    frame({32'h3455aa40, 32'h0}, 3, 0);
    repeat (30) @(negedge clk);
    check(lock_en, 1'b1);
    frame({32'h3455aa40, 32'h3d2a7f30}, 6, 0);
    repeat (30) @(negedge clk);
    wait_idle();
    check(lock_en, 1'b0);
    lock(24'h050000, 7);
    repeat (30) @(negedge clk);
    check(lock_state, exp);
    check(lock_en, 1'b0);
    wrap_up();
  end
endmodule : tb
